// ### pkg/rts_pkg.sv
// Package: constants, register map and carrier types of the reset sequencer.
package rts_pkg;
  // Clock rate and sequencer timing.
  localparam int CLK_KHZ       = 250000;
  localparam int DELAY_TIME_MS = 72;
  localparam int DELAY_CYCLES  = DELAY_TIME_MS * CLK_KHZ;
  localparam int DELAY_W       = 25;
  localparam int SETTLE_EDGES  = 1024;
  localparam int SETTLE_W      = 11;
  localparam int FILT_CYCLES   = 4;
  localparam int FILT_W        = 3;

  // Register map, byte addresses on the AXI4-Lite slave.
  localparam int         AXI_AW     = 4;
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_CFG    = 4'h4;
  localparam logic [3:0] OFS_SEQ    = 4'h8;

  // Field positions.
  localparam int BIT_BROWNOUT_N = 0;
  localparam int BIT_PWR_ON_N   = 1;
  localparam int BIT_WDT_N      = 0;
  localparam int BIT_SLEEP_N    = 1;
  localparam int BIT_CHIP_RST   = 2;
  localparam int BIT_STATE_LO   = 3;
  localparam int CFG_W          = 4;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    LOW_POWER_CRYSTAL_MODE      = 2'b00,
    CRYSTAL_MODE                = 2'b01,
    HIGH_SPEED_CRYSTAL_MODE     = 2'b10,
    RESISTOR_CAPACITOR_OSC_MODE = 2'b11
  } rts_osc_t;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_HOLD   = 2'b01,
    ST_DELAY  = 2'b10,
    ST_SETTLE = 2'b11
  } rts_state_t;

  typedef struct packed {
    rts_osc_t osc_mode;
    logic     brownout_detect_enable;
    logic     power_up_delay_enable_n;
  } rts_cfg_t;

  typedef struct packed {
    logic power_on_pulse;
    logic brownout;
    logic wdt_timeout;
    logic sleeping;
    logic wake_irq;
  } rts_src_t;

  // Reset values.
  localparam rts_cfg_t   CFG_RESET    = '{CRYSTAL_MODE, 1'b1, 1'b0};
  localparam logic [1:0] STATUS_RESET = 2'h1;
  localparam logic [1:0] FLAGS_RESET  = 2'h3;
endpackage

// ### hdl/rts_down_cnt.sv
// Loadable down counter used for the delay and settle timers.
`timescale 1ns/1ns
module rts_down_cnt #(
  parameter int W = 11
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         aclk_en,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         tick,
  output logic      [W-1:0] count,
  output logic              zero
);
  // Load wins over a tick so a restart always begins from the full count.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (aclk_en) begin
      if (load) begin
        count <= load_val;
      end else if (tick && (count != '0)) begin
        count <= count - 1'b1;
      end
    end
  end

  // Zero marks an expired timer.
  assign zero = (count == '0);
endmodule

// ### hdl/rts_sequencer.sv
// Reset time-out sequencer with power status flags and an AXI4-Lite slave.
// Contract
// R1: A power-on pulse starts the time-out sequence without any external pin help.
// R2: Power-up delay runs from the power-on pulse; chip stays in reset meanwhile.
// R3: Active-low enable bit zero applies the power-up delay; one skips it.
// R4: After the delay, 1024 oscillator pin cycles are counted before release.
// R5: Oscillator count only in crystal modes, on power-on or sleep wake-up.
// R6: Brownout detect enable bit clear disables brownout reset; set enables it.
// R7: Brownout holds reset; on recovery the full power-up delay runs.
// R8: Brownout during the delay returns to hold and restarts the full delay.
// R9: Configuration should keep the delay enabled whenever brownout reset is on.
// R10: Power-up runs the delay after the pulse ends, then the oscillator count.
// R11: Resistor-capacitor mode with delay disabled applies no time-out at all.
// R12: Time-outs ignore the external pin; raising it later releases immediately.
// R13: Status bit 0 is active-low brownout flag, set on power-on if enabled.
// R14: Software sets the brownout flag and reads a cleared flag as brownout.
// R15: Power-on clears status bit 1; software sets it; other resets keep it.
// R16: Total delay per oscillator mode and cause follows the time-out table.
// R17: Power-on clears power-on flag and sets timeout and sleep flags.
// R18: Reset causes mark brownout, timeout and sleep flags as tabulated.
// R19: A watchdog reset resets the chip without driving the external pin.
// R20: Short glitches on the external reset pin are filtered out.
// R21: Chip reset holds while any source or either timer is active.
// R22: Both timers reload whenever a new power-on or brownout reset begins.
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
module rts_sequencer #(
  parameter int DELAY_CYCLES = rts_pkg::DELAY_CYCLES
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       aclk_en,
  input  wire rts_pkg::rts_src_t          src,
  input  wire logic                       external_reset_pin_n,
  input  wire logic                       oscillator_input_pin,
  input  wire logic [rts_pkg::AXI_AW-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [rts_pkg::AXI_AW-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  output logic                            chip_reset
);
  import rts_pkg::*;

  rts_state_t           st_r;
  rts_state_t           st_nxt;
  rts_cfg_t             cfg_r;
  logic                 pwr_on_cause_r;
  logic [1:0]           status_r;
  logic                 wdt_flag_n_r;
  logic                 sleep_flag_n_r;
  logic [FILT_W-1:0]    filt_cnt_r;
  logic                 ext_rst_r;
  logic                 ext_rst_nxt;
  logic                 osc_prev_r;
  logic                 osc_rise;
  logic                 chip_reset_r;
  logic                 brownout_on;
  logic                 crystal;
  logic                 wdt_rst;
  logic                 wake_ev;
  logic                 delay_load;
  logic                 settle_load;
  logic                 delay_zero;
  logic                 settle_zero;
  logic [DELAY_W-1:0]   delay_cnt;
  logic [AXI_AW-1:0]    waddr_r;
  logic [31:0]          wdata_r;
  logic [3:0]           wstrb_r;
  logic                 awready_r;
  logic                 wready_r;
  logic                 bvalid_r;
  logic [1:0]           bresp_r;
  logic                 arready_r;
  logic                 rvalid_r;
  logic [1:0]           rresp_r;
  logic [31:0]          rdata_r;
  logic                 wr_go;
  logic                 wr_status;
  logic                 wr_cfg;
  logic [31:0]          rd_word;
  logic                 rd_err;

  // Decoded sources; a disabled brownout detector is simply ignored.
  assign brownout_on = src.brownout && cfg_r.brownout_detect_enable;  // R6
  assign crystal     = (cfg_r.osc_mode != RESISTOR_CAPACITOR_OSC_MODE);
  assign wdt_rst     = src.wdt_timeout && !src.sleeping;
  assign wake_ev     = src.sleeping && (src.wdt_timeout || src.wake_irq);
  assign osc_rise    = oscillator_input_pin && !osc_prev_r;

  // The pin is already synchronous, so one stage is enough for the edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_prev_r <= 1'b0;
    end else if (aclk_en) begin
      osc_prev_r <= oscillator_input_pin;
    end
  end

  // Pin glitch filter: only a low of FILT_CYCLES in a row is a reset.
  // Release is not filtered, so a held pin lets go at once.
  always_comb begin
    ext_rst_nxt = !external_reset_pin_n &&
                  (ext_rst_r || (filt_cnt_r == FILT_W'(FILT_CYCLES - 1)));  // R20
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_cnt_r <= '0;
      ext_rst_r  <= 1'b0;
    end else if (aclk_en) begin
      ext_rst_r <= ext_rst_nxt;
      if (external_reset_pin_n) begin
        filt_cnt_r <= '0;
      end else if (filt_cnt_r != FILT_W'(FILT_CYCLES - 1)) begin
        filt_cnt_r <= filt_cnt_r + 1'b1;
      end
    end
  end

  // Sequencer next state. Power-on and brownout override everything and
  // hold the machine until the source goes away.
  always_comb begin
    st_nxt = st_r;
    if (src.power_on_pulse || brownout_on) begin
      st_nxt = ST_HOLD;  // R1 R7 R8
    end else begin
      unique case (st_r)
        ST_HOLD: begin
          // Brownout recovery always runs the delay; power-on obeys the bit.
          if (!cfg_r.power_up_delay_enable_n || !pwr_on_cause_r) begin
            st_nxt = ST_DELAY;  // R3 R7 R10
          end else if (crystal) begin
            st_nxt = ST_SETTLE;  // R5 R16
          end else begin
            st_nxt = ST_RUN;  // R11
          end
        end
        ST_DELAY: begin
          if (delay_zero) begin
            st_nxt = crystal ? ST_SETTLE : ST_RUN;  // R4 R16
          end
        end
        ST_SETTLE: begin
          if (settle_zero) begin
            st_nxt = ST_RUN;  // R4
          end
        end
        ST_RUN: begin
          if (wake_ev && crystal) begin
            st_nxt = ST_SETTLE;  // R5
          end
        end
      endcase
    end
  end

  // Timers reload on entry and all through hold, so a fresh reset
  // never inherits a half-spent count.
  assign delay_load  = (st_nxt == ST_HOLD) || ((st_nxt == ST_DELAY) && (st_r != ST_DELAY));  // R22
  assign settle_load = (st_nxt == ST_HOLD) ||
                       ((st_nxt == ST_SETTLE) && (st_r != ST_SETTLE));  // R22

  // Power-up delay timer, one tick per clock.
  rts_down_cnt #(
    .W (DELAY_W)
  ) u_delay (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .aclk_en  (aclk_en),
    .load     (delay_load),
    .load_val (DELAY_W'(DELAY_CYCLES - 1)),
    .tick     (st_r == ST_DELAY),
    .count    (delay_cnt),
    .zero     (delay_zero)
  );

  // Clock settle timer, one tick per rising edge of the oscillator pin.
  rts_down_cnt #(
    .W (SETTLE_W)
  ) u_settle (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .aclk_en  (aclk_en),
    .load     (settle_load),
    .load_val (SETTLE_W'(SETTLE_EDGES)),
    .tick     ((st_r == ST_SETTLE) && osc_rise),
    .count    (),
    .zero     (settle_zero)
  );

  // State, cause memory and the chip reset output. The watchdog reset
  // acts only here and never reaches the external pin.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r           <= ST_HOLD;
      pwr_on_cause_r <= 1'b1;
      chip_reset_r   <= 1'b1;
    end else if (aclk_en) begin
      st_r         <= st_nxt;
      chip_reset_r <= (st_nxt != ST_RUN) || ext_rst_nxt || wdt_rst;  // R2 R12 R19 R21
      if (src.power_on_pulse) begin
        pwr_on_cause_r <= 1'b1;
      end else if (brownout_on) begin
        pwr_on_cause_r <= 1'b0;
      end
    end
  end

  // Power status flags. Hardware events win over a software write in
  // the same cycle so no reset cause is lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= STATUS_RESET;
    end else if (aclk_en) begin
      if (src.power_on_pulse) begin
        status_r[BIT_PWR_ON_N] <= 1'b0;  // R15 R17
        if (cfg_r.brownout_detect_enable) begin
          status_r[BIT_BROWNOUT_N] <= 1'b1;  // R13
        end
      end else if (brownout_on) begin
        status_r[BIT_BROWNOUT_N] <= 1'b0;  // R18
      end else if (wr_status) begin
        status_r <= wdata_r[1:0];  // R14 R15
      end
    end
  end

  // Timeout and sleep flags mark the cause of each reset or wake-up.
  // An external reset while running leaves both as they are.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {sleep_flag_n_r, wdt_flag_n_r} <= FLAGS_RESET;
    end else if (aclk_en) begin
      if (src.power_on_pulse || brownout_on) begin
        wdt_flag_n_r   <= 1'b1;  // R17 R18
        sleep_flag_n_r <= 1'b1;
      end else if (src.wdt_timeout) begin
        wdt_flag_n_r   <= 1'b0;  // R18
        sleep_flag_n_r <= !src.sleeping;
      end else if (src.sleeping && (src.wake_irq || (ext_rst_nxt && !ext_rst_r))) begin
        wdt_flag_n_r   <= 1'b1;  // R18
        sleep_flag_n_r <= 1'b0;
      end
    end
  end

  // Configuration register; it survives chip resets, only aresetn returns it to CFG_RESET.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= CFG_RESET;
    end else if (aclk_en && wr_cfg) begin
      cfg_r <= rts_cfg_t'(wdata_r[CFG_W-1:0]);  // R3 R6
    end
  end

  // Write channel: address and data are caught in either order and the
  // write happens once both are in, one transaction at a time.
  assign wr_go     = !awready_r && !wready_r && !bvalid_r;
  assign wr_status = wr_go && (waddr_r == OFS_STATUS) && wstrb_r[0];
  assign wr_cfg    = wr_go && (waddr_r == OFS_CFG) && wstrb_r[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      waddr_r   <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end else if (aclk_en) begin
      if (awvalid && awready_r) begin
        awready_r <= 1'b0;
        waddr_r   <= awaddr;
      end
      if (wvalid && wready_r) begin
        wready_r <= 1'b0;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= ((waddr_r == OFS_STATUS) || (waddr_r == OFS_CFG)) ? RESP_OKAY
                                                                      : RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // Read decode; unused upper bits read as zero.
  always_comb begin
    rd_word = '0;
    rd_err  = 1'b0;
    unique case (araddr)
      OFS_STATUS: rd_word[1:0] = status_r;
      OFS_CFG:    rd_word[CFG_W-1:0] = cfg_r;
      OFS_SEQ: begin
        rd_word[BIT_WDT_N]                   = wdt_flag_n_r;
        rd_word[BIT_SLEEP_N]                 = sleep_flag_n_r;
        rd_word[BIT_CHIP_RST]                = chip_reset_r;
        rd_word[BIT_STATE_LO+1:BIT_STATE_LO] = st_r;
      end
      default: rd_err = 1'b1;
    endcase
  end

  // Read channel: the answer follows the address by one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= '0;
    end else if (aclk_en) begin
      if (arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rd_word;
        rresp_r   <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid_r && rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  assign awready    = awready_r;
  assign wready     = wready_r;
  assign bvalid     = bvalid_r;
  assign bresp      = bresp_r;
  assign arready    = arready_r;
  assign rvalid     = rvalid_r;
  assign rresp      = rresp_r;
  assign rdata      = rdata_r;
  assign chip_reset = chip_reset_r;

  // Checks; a frozen clock enable abandons any attempt in flight.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !aclk_en);

  // Helper: oscillator edges seen while settling.
  logic [SETTLE_W:0] edge_seen_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_seen_r <= '0;
    end else if (aclk_en) begin
      if (st_r != ST_SETTLE) begin
        edge_seen_r <= '0;
      end else if (osc_rise) begin
        edge_seen_r <= edge_seen_r + 1'b1;
      end
    end
  end

  sequence pin_low_s;
    !external_reset_pin_n [*4];
  endsequence

  sequence hold_done_s;
    (st_r == ST_HOLD) && !src.power_on_pulse && !brownout_on;
  endsequence

  pwr_on_reset_a: assert property (src.power_on_pulse |=> chip_reset_r && (st_r == ST_HOLD))  // R1
    else $error("Power-on pulse did not enter hold.");
  delay_holds_a: assert property ((st_r == ST_DELAY) |-> chip_reset_r)  // R2
    else $error("Chip released during power-up delay.");
  delay_skip_a: assert property (hold_done_s and (cfg_r.power_up_delay_enable_n && pwr_on_cause_r)
                                 |=> st_r != ST_DELAY)  // R3
    else $error("Disabled power-up delay still ran.");
  settle_count_a: assert property ($fell(st_r == ST_SETTLE) && (st_r == ST_RUN)
                                   |-> edge_seen_r == (SETTLE_W + 1)'(SETTLE_EDGES))  // R4
    else $error("Settle count was not 1024 edges.");
  // Checked at entry only, since software may change the mode while a count runs.
  settle_mode_a: assert property ((st_r != ST_SETTLE) && (st_nxt == ST_SETTLE) |-> crystal)  // R5
    else $error("Settle count ran in RC mode.");
  brownout_restart_a: assert property ((st_r == ST_DELAY) && brownout_on
                                       |=> (st_r == ST_HOLD) ##1 delay_cnt != '0)  // R8
    else $error("Brownout did not restart the delay.");
  no_timeout_a: assert property (hold_done_s and
                                 (cfg_r.power_up_delay_enable_n && pwr_on_cause_r && !crystal)
                                 |=> st_r == ST_RUN)  // R11
    else $error("RC mode without delay still timed out.");
  pin_release_a: assert property (ext_rst_r && external_reset_pin_n && (st_nxt == ST_RUN) &&
                                  !wdt_rst |=> !chip_reset_r)  // R12
    else $error("Release after pin rise was delayed.");
  pin_filter_a: assert property (pin_low_s |=> ext_rst_r && chip_reset_r)  // R20
    else $error("Held pin low did not reset.");
  pwr_on_flags_a: assert property (src.power_on_pulse |=> !status_r[BIT_PWR_ON_N] &&
                                   wdt_flag_n_r && sleep_flag_n_r)  // R17
    else $error("Power-on flags wrong.");
  brownout_flag_a: assert property (brownout_on && !src.power_on_pulse
                                    |=> !status_r[BIT_BROWNOUT_N])  // R18
    else $error("Brownout flag not cleared.");
  wdt_reset_a: assert property (wdt_rst && !src.power_on_pulse && !brownout_on
                                |=> chip_reset_r && !wdt_flag_n_r && sleep_flag_n_r)  // R19
    else $error("Watchdog reset marked wrongly.");
endmodule

// ### tb/rts_sequencer_tb_top.sv
// Self-checking bench for the reset time-out sequencer, driven over its register bus.
`timescale 1ns/1ns
module rts_sequencer_tb_top;
  import rts_pkg::*;
  localparam int D = 20;
  logic        aclk      = 1'b0;
  logic        aresetn   = 1'b0;
  rts_src_t    src       = '0;
  logic        pin_n     = 1'b1;
  logic        osc       = 1'b0;
  logic [3:0]  awaddr    = 4'h0;
  logic        awvalid   = 1'b0;
  logic [31:0] wdata     = 32'h0;
  logic [3:0]  wstrb     = 4'hf;
  logic        wvalid    = 1'b0;
  logic        bready    = 1'b1;
  logic [3:0]  araddr    = 4'h0;
  logic        arvalid   = 1'b0;
  logic        rready    = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, chip_reset;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic        hi;
  int          failures  = 0;
  int          checks    = 0;
  // Settings that skip the delay also turn brownout reset off.
  logic [3:0]  cfg_tab [6] = '{4'h6, 4'h5, 4'he, 4'hd, 4'h2, 4'ha};
  int          lo_tab  [6] = '{D + 2040, 2040, D, 0, D + 2040, D + 2040};
  int          hi_tab  [6] = '{D + 2062, 2062, D + 5, 3, D + 2062, D + 2062};

  rts_sequencer #(.DELAY_CYCLES(D)) rts_sequencer_i (
    .aclk(aclk), .aresetn(aresetn), .aclk_en(1'b1), .src(src),
    .external_reset_pin_n(pin_n), .oscillator_input_pin(osc),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .chip_reset(chip_reset)
  );

  // Clock at 4 ns; the oscillator pin toggles every cycle so a rising edge comes every two.
  initial begin
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    osc <= ~osc;
  end

  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected resp at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A window is used because the settle count starts on a free-running pin phase.
  task automatic check_cycles(input int got, input int lo, input int hi_b);
    checks++;
    if (got < lo || got > hi_b) begin
      failures++;
      $display("unexpected cycles at %0t: got %h expected %h..%h", $time, got, lo, hi_b);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Looks at the chip reset once settled, then returns on the next edge.
  task automatic probe(input logic exp);
    #1;
    check_data({31'h0, chip_reset}, {31'h0, exp});
    @(posedge aclk);
  endtask

  // Both channels are offered together and each is dropped only at its own handshake.
  // The response readies stay high, so the answer is taken at the first edge it stands;
  // a hang is left to the watchdog.
  task automatic axi_write(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s,
                           output logic [1:0] resp);
    awaddr  <= a;
    wdata   <= v;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (!(bready && bvalid === 1'b1));
    resp = bresp;
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] v,
                          output logic [1:0] resp);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (!(rready && rvalid === 1'b1));
    v = rdata;
    resp = rresp;
  endtask

  task automatic reg_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    axi_read(a, d, r);
    check_resp(r, RESP_OKAY);
    check_data(d & m, e);
  endtask

  task automatic wait_release(input int lo, input int hi_b);
    int n;
    n = 0;
    while (chip_reset !== 1'b0 && n < 5000) begin
      @(posedge aclk);
      #1;
      n++;
    end
    check_cycles(n, lo, hi_b);
    // Return on an edge so the next request is driven there.
    @(posedge aclk);
  endtask

  task automatic pulse(input int which);
    if (which == 0) src.power_on_pulse <= 1'b1;
    if (which == 1) src.wdt_timeout <= 1'b1;
    if (which == 2) src.wake_irq <= 1'b1;
    @(posedge aclk);
    src.power_on_pulse <= 1'b0;
    src.wdt_timeout <= 1'b0;
    src.wake_irq <= 1'b0;
    src.sleeping <= 1'b0;
    #1;
  endtask

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // The whole run needs about 15000 cycles; a hang is cut short well beyond that.
  initial begin
    repeat (60000) @(posedge aclk);
    failures++;
    print_verdict();
  end

  initial begin
    cyc(20);
    aresetn <= 1'b1;
    wait_release(D + 2040, D + 2064);
    reg_chk(OFS_STATUS, 32'hffffffff, 32'h1);
    reg_chk(OFS_CFG, 32'hffffffff, 32'h6);
    reg_chk(OFS_SEQ, 32'h3, 32'h3);
    axi_read(4'hc, d, r);
    check_resp(r, RESP_SLVERR);
    axi_write(OFS_SEQ, 32'h0, 4'hf, r);
    check_resp(r, RESP_SLVERR);
    axi_write(OFS_CFG, 32'h0, 4'h0, r);
    check_resp(r, RESP_OKAY);
    reg_chk(OFS_CFG, 32'hffffffff, 32'h6);
    // Every oscillator mode and delay setting after a power-on pulse.
    for (int i = 0; i < 6; i++) begin
      axi_write(OFS_CFG, {28'h0, cfg_tab[i]}, 4'hf, r);
      axi_write(OFS_STATUS, 32'h3, 4'hf, r);
      pulse(0);
      wait_release(lo_tab[i], hi_tab[i]);
      reg_chk(OFS_STATUS, 32'h3, 32'h1);
      reg_chk(OFS_SEQ, 32'h3, 32'h3);
    end
    // Brownout in RC mode runs the full delay on recovery; a second one restarts it.
    axi_write(OFS_CFG, 32'he, 4'hf, r);
    axi_write(OFS_STATUS, 32'h3, 4'hf, r);
    src.brownout <= 1'b1;
    cyc(3);
    probe(1'b1);
    reg_chk(OFS_STATUS, 32'h3, 32'h2);
    reg_chk(OFS_SEQ, 32'h3, 32'h3);
    src.brownout <= 1'b0;
    cyc(D / 2);
    src.brownout <= 1'b1;
    cyc(2);
    src.brownout <= 1'b0;
    wait_release(D, D + 5);
    // Brownout input is ignored with detection disabled.
    axi_write(OFS_CFG, 32'hd, 4'hf, r);
    src.brownout <= 1'b1;
    cyc(4);
    probe(1'b0);
    src.brownout <= 1'b0;
    axi_write(OFS_CFG, 32'h6, 4'hf, r);
    // Watchdog reset while running, then watchdog and interrupt wake from sleep.
    pulse(1);
    check_data({31'h0, chip_reset}, 32'h1);
    wait_release(0, 3);
    reg_chk(OFS_SEQ, 32'h3, 32'h2);
    src.sleeping <= 1'b1;
    cyc(1);
    pulse(1);
    wait_release(2040, 2062);
    reg_chk(OFS_SEQ, 32'h3, 32'h0);
    src.sleeping <= 1'b1;
    cyc(1);
    pulse(2);
    wait_release(2040, 2062);
    reg_chk(OFS_SEQ, 32'h3, 32'h1);
    // A three-cycle low on the pin is filtered; a long low resets and releases at once.
    pin_n <= 1'b0;
    hi = 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      if (i == 2) pin_n <= 1'b1;
      #1;
      hi = hi | chip_reset;
    end
    check_data({31'h0, hi}, 32'h0);
    @(posedge aclk);
    pin_n <= 1'b0;
    cyc(7);
    probe(1'b1);
    reg_chk(OFS_SEQ, 32'h3, 32'h1);
    pin_n <= 1'b1;
    wait_release(1, 2);
    print_verdict();
  end
endmodule
